// ==== src/mmuxc_top.sv ====
// mmu exception classifier, segment moves and translation-buffer upkeep
// register port answers reads one cycle later; inputs other than arst_n are synchronous to clk
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "mmuxc_regs.svh"
module mmuxc_top #(
  parameter int SETS = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic acc_valid,
  input wire mmuxc_pkg::mmuxc_acc_e acc_kind,
  input wire logic [31:0] acc_ea,
  input wire logic acc_misal,
  input wire logic acc_wt,
  input wire logic acc_ci,
  output logic exc_valid,
  output mmuxc_pkg::mmuxc_exc_e exc_code,
  output logic [19:0] exc_vector,
  output logic acc_hit,
  output logic [31:0] acc_ppg,
  input wire logic op_valid,
  input wire mmuxc_pkg::mmuxc_op_e op_code,
  input wire logic [3:0] op_seg,
  input wire logic [31:0] op_rs,
  input wire logic [31:0] op_rb,
  output logic op_done,
  output logic op_illegal,
  output logic [31:0] op_rdata,
  input wire logic tlbi_sync,
  output logic core_stall
);
  logic rst_s1_r;
  logic rst_n;
  logic [31:0] ms_r;
  logic [31:0] imp0_r;
  logic [31:0] ext_r;
  logic [31:0] ss_r;
  logic [31:0] fc_r;
  logic [31:0] ima_r;
  logic [31:0] dma_r;
  logic [31:0] icmpw_r;
  logic [31:0] dcmpw_r;
  logic [31:0] ppg_r;
  logic [31:0] seg_r [16];
  mmuxc_pkg::mmuxc_state_e state_r;
  mmuxc_pkg::mmuxc_state_e state_nxt;
  logic [31:0] seg_cur;
  logic [31:0] key;
  logic [4:0] idx;
  logic acc_go;
  logic op_go;
  logic inv_go;
  logic ld_i;
  logic ld_d;
  logic i_hit;
  logic d_hit;
  logic [31:0] i_ppg;
  logic [31:0] d_ppg;
  mmuxc_pkg::mmuxc_exc_e exc_nxt;
  logic [31:0] fc_nxt;
  logic [3:0] sel;

  if (SETS != 32) begin : g_chk
    $error("mmuxc_top: SETS must be 32");
  end

  // reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // accesses and ops are refused while the core is stalled
  assign acc_go = acc_valid && state_r == mmuxc_pkg::ST_RUN;
  assign op_go = op_valid && state_r == mmuxc_pkg::ST_RUN;
  assign inv_go = op_go && op_code == mmuxc_pkg::OP_INV_ENT;
  assign ld_i = op_go && op_code == mmuxc_pkg::OP_LOAD_I;
  assign ld_d = op_go && op_code == mmuxc_pkg::OP_LOAD_D;
  assign seg_cur = seg_r[acc_ea[31:28]];
  // compare word: valid, segment id, primary hash, page index bits 4-9
  assign key = {1'b1, seg_cur[23:0], 1'b0, acc_ea[27:22]};
  assign idx = op_go ? op_rb[`MMUXC_IDX_HI:`MMUXC_IDX_LO] : acc_ea[`MMUXC_IDX_HI:`MMUXC_IDX_LO];
  assign sel = (op_code == mmuxc_pkg::OP_MTSEG_IND || op_code == mmuxc_pkg::OP_MFSEG_IND) ?
               op_rb[`MMUXC_SEL_HI:`MMUXC_SEL_LO] : op_seg;

  mmuxc_tlb #(.SETS(SETS)) u_instr_xlate_buffer (
    .clk(clk),
    .rst_n(rst_n),
    .idx(idx),
    .key(key),
    .hit(i_hit),
    .hit_ppg(i_ppg),
    .load_en(ld_i),
    .load_cmp(icmpw_r),
    .load_ppg(ppg_r),
    .inv_en(inv_go)
  );

  mmuxc_tlb #(.SETS(SETS)) u_data_xlate_buffer (
    .clk(clk),
    .rst_n(rst_n),
    .idx(idx),
    .key(key),
    .hit(d_hit),
    .hit_ppg(d_ppg),
    .load_en(ld_d),
    .load_cmp(dcmpw_r),
    .load_ppg(ppg_r),
    .inv_en(inv_go)
  );

  mmuxc_fault u_fault (
    .kind(acc_kind),
    .xlate_i(ms_r[`MMUXC_MS_XI]),
    .xlate_d(ms_r[`MMUXC_MS_XD]),
    .misal(acc_misal),
    .wt(acc_wt),
    .ci(acc_ci),
    .dlock(imp0_r[`MMUXC_IMP0_LK18] | imp0_r[`MMUXC_IMP0_LK19]),
    .swap(ms_r[`MMUXC_MS_SWAP]),
    .ext_en(ext_r[`MMUXC_EXT_EN]),
    .seg_t(seg_cur[`MMUXC_SEG_T]),
    .hit(acc_kind == mmuxc_pkg::ACC_FETCH ? i_hit : d_hit),
    .changed(d_ppg[`MMUXC_PPG_C]),
    .exc(exc_nxt),
    .fc(fc_nxt)
  );

  // software-only registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      imp0_r <= `MMUXC_RST_WORD;
      ext_r <= `MMUXC_RST_WORD;
      ppg_r <= `MMUXC_RST_WORD;
    end else if (reg_wr) begin
      if (reg_addr == `MMUXC_OFF_IMP0) imp0_r <= reg_wdata;
      if (reg_addr == `MMUXC_OFF_EXT) ext_r <= reg_wdata;
      if (reg_addr == `MMUXC_OFF_PPG) ppg_r <= reg_wdata;
    end
  end

  // cause and state words: an exception in the same cycle beats a write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_r <= `MMUXC_RST_WORD;
      ss_r <= `MMUXC_RST_WORD;
      fc_r <= `MMUXC_RST_WORD;
    end else begin
      if (reg_wr && reg_addr == `MMUXC_OFF_MS) ms_r <= reg_wdata;
      if (reg_wr && reg_addr == `MMUXC_OFF_SS) ss_r <= reg_wdata;
      if (reg_wr && reg_addr == `MMUXC_OFF_FC) fc_r <= reg_wdata;
      if (acc_go) begin
        unique case (exc_nxt)
          mmuxc_pkg::EXC_INSTR_MISS_ADDR_REG: begin
            ss_r[`MMUXC_SS_B13] <= 1'b1;
            ms_r[`MMUXC_MS_B14] <= 1'b1;
          end
          mmuxc_pkg::EXC_DLMISS: begin
            ss_r[`MMUXC_SS_B13] <= 1'b0;
            ss_r[`MMUXC_SS_B15] <= 1'b1;
            ms_r[`MMUXC_MS_B14] <= 1'b1;
          end
          mmuxc_pkg::EXC_DSMISS: begin
            ss_r[`MMUXC_SS_B13] <= 1'b0;
            ss_r[`MMUXC_SS_B15] <= 1'b0;
            ms_r[`MMUXC_MS_B14] <= 1'b1;
          end
          mmuxc_pkg::EXC_DSTOR: fc_r <= fc_nxt;
          mmuxc_pkg::EXC_ALIGN, mmuxc_pkg::EXC_NONE: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ima_r <= `MMUXC_RST_WORD;
      dma_r <= `MMUXC_RST_WORD;
      icmpw_r <= `MMUXC_RST_WORD;
      dcmpw_r <= `MMUXC_RST_WORD;
    end else if (acc_go && exc_nxt == mmuxc_pkg::EXC_INSTR_MISS_ADDR_REG) begin
      ima_r <= acc_ea;
      icmpw_r <= key;
    end else if (acc_go && (exc_nxt == mmuxc_pkg::EXC_DLMISS || exc_nxt == mmuxc_pkg::EXC_DSMISS)) begin
      dma_r <= acc_ea;
      dcmpw_r <= key;
    end
  end

  // exception report, one cycle after the access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exc_valid <= 1'b0;
      exc_code <= mmuxc_pkg::EXC_NONE;
      exc_vector <= 20'h00000;
      acc_hit <= 1'b0;
      acc_ppg <= 32'h00000000;
    end else begin
      exc_valid <= acc_go && exc_nxt != mmuxc_pkg::EXC_NONE;
      exc_code <= acc_go ? exc_nxt : mmuxc_pkg::EXC_NONE;
      exc_vector <= (acc_go && exc_nxt == mmuxc_pkg::EXC_ALIGN) ? `MMUXC_VEC_ALIGN : 20'h00000;
      acc_hit <= acc_go && (acc_kind == mmuxc_pkg::ACC_FETCH ? i_hit : d_hit);
      acc_ppg <= acc_go ? (acc_kind == mmuxc_pkg::ACC_FETCH ? i_ppg : d_ppg) : 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < 16; s++) begin
        seg_r[s] <= `MMUXC_RST_WORD;
      end
    end else if (op_go && (op_code == mmuxc_pkg::OP_MTSEG || op_code == mmuxc_pkg::OP_MTSEG_IND)) begin
      seg_r[sel] <= op_rs;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      mmuxc_pkg::ST_RUN: if (op_go && op_code == mmuxc_pkg::OP_INV_SYNC && tlbi_sync) begin
        state_nxt = mmuxc_pkg::ST_SYNC;
      end
      mmuxc_pkg::ST_SYNC: if (!tlbi_sync) begin
        state_nxt = mmuxc_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= mmuxc_pkg::ST_RUN;
      core_stall <= 1'b0;
    end else begin
      state_r <= state_nxt;
      core_stall <= state_nxt == mmuxc_pkg::ST_SYNC;
    end
  end

  // op completion; the sync op completes in the same cycle the stall starts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_done <= 1'b0;
      op_illegal <= 1'b0;
      op_rdata <= 32'h00000000;
    end else begin
      op_done <= op_go;
      op_illegal <= op_go && (op_code == mmuxc_pkg::OP_INV_ALL || op_code > mmuxc_pkg::OP_LOAD_D);
      op_rdata <= (op_go && (op_code == mmuxc_pkg::OP_MFSEG || op_code == mmuxc_pkg::OP_MFSEG_IND)) ?
                  seg_r[sel] : 32'h00000000;
    end
  end

  // register read, valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `MMUXC_OFF_MS: reg_rdata <= ms_r;
        `MMUXC_OFF_IMP0: reg_rdata <= imp0_r;
        `MMUXC_OFF_EXT: reg_rdata <= ext_r;
        `MMUXC_OFF_SS: reg_rdata <= ss_r;
        `MMUXC_OFF_FC: reg_rdata <= fc_r;
        `MMUXC_OFF_IMA: reg_rdata <= ima_r;
        `MMUXC_OFF_DMA: reg_rdata <= dma_r;
        `MMUXC_OFF_ICMPW: reg_rdata <= icmpw_r;
        `MMUXC_OFF_DCMPW: reg_rdata <= dcmpw_r;
        `MMUXC_OFF_PPG: reg_rdata <= ppg_r;
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  sequence s_fetch_miss;
    acc_go && acc_kind == mmuxc_pkg::ACC_FETCH && ms_r[`MMUXC_MS_XI] && !i_hit;
  endsequence

  sequence s_load_miss;
    acc_go && acc_kind == mmuxc_pkg::ACC_LOAD && ms_r[`MMUXC_MS_XD] && !acc_misal &&
    !seg_cur[`MMUXC_SEG_T] && !d_hit;
  endsequence

  instr_miss_addr_reg_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_fetch_miss |=> exc_code == mmuxc_pkg::EXC_INSTR_MISS_ADDR_REG && ss_r[`MMUXC_SS_B13] && ms_r[`MMUXC_MS_B14]
    && ima_r == $past(acc_ea))
    else $error("fetch miss not reported");
  dload_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_load_miss |=> exc_valid && !ss_r[`MMUXC_SS_B13] && ss_r[`MMUXC_SS_B15] && ms_r[`MMUXC_MS_B14])
    else $error("load miss bits wrong");
  dstore_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    exc_code == mmuxc_pkg::EXC_DSMISS |-> !ss_r[`MMUXC_SS_B13] && !ss_r[`MMUXC_SS_B15])
    else $error("store miss bits wrong");
  zero_align_a: assert property (@(posedge clk) disable iff (!rst_n)
    acc_go && acc_kind == mmuxc_pkg::ACC_ZERO && imp0_r[`MMUXC_IMP0_LK19] |=>
    exc_code == mmuxc_pkg::EXC_ALIGN && exc_vector == 20'h00600)
    else $error("locked zeroing not aligned");
  nodata_xlate_a: assert property (@(posedge clk) disable iff (!rst_n)
    acc_go && acc_kind != mmuxc_pkg::ACC_FETCH && !ms_r[`MMUXC_MS_XD] |=>
    exc_code inside {mmuxc_pkg::EXC_NONE, mmuxc_pkg::EXC_ALIGN})
    else $error("fault without data translation");
  ext_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    exc_code == mmuxc_pkg::EXC_DSTOR |-> fc_r[`MMUXC_FC_B5] != fc_r[`MMUXC_FC_B11])
    else $error("storage fault cause wrong");
  inv_all_a: assert property (@(posedge clk) disable iff (!rst_n)
    op_go && op_code == mmuxc_pkg::OP_INV_ALL |=> op_done && op_illegal)
    else $error("invalidate-all not illegal");
  sync_stall_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == mmuxc_pkg::ST_SYNC && !tlbi_sync |=> !core_stall ##1 !core_stall || $past(tlbi_sync))
    else $error("stall outlives sync input");
  seg_move_a: assert property (@(posedge clk) disable iff (!rst_n)
    op_go && op_code == mmuxc_pkg::OP_MTSEG_IND |=> seg_r[$past(op_rb[31:28])] == $past(op_rs))
    else $error("segment write lost");
endmodule : mmuxc_top
`default_nettype wire

// ==== src/mmuxc_regs.svh ====
// offsets, bit positions and reset values of the mmu exception/tlb control block
// bit numbers are lsb-based in code: big-endian bit n of a word is bit 31-n here
`ifndef MMUXC_REGS_SVH
`define MMUXC_REGS_SVH
`define MMUXC_OFF_MS 8'h00
`define MMUXC_OFF_IMP0 8'h04
`define MMUXC_OFF_EXT 8'h08
`define MMUXC_OFF_SS 8'h0C
`define MMUXC_OFF_FC 8'h10
`define MMUXC_OFF_IMA 8'h14
`define MMUXC_OFF_DMA 8'h18
`define MMUXC_OFF_ICMPW 8'h1C
`define MMUXC_OFF_DCMPW 8'h20
`define MMUXC_OFF_PPG 8'h24
`define MMUXC_SS_B13 18
`define MMUXC_SS_B15 16
`define MMUXC_MS_B14 17
`define MMUXC_MS_XD 4
`define MMUXC_MS_XI 5
`define MMUXC_MS_SWAP 0
`define MMUXC_FC_B5 26
`define MMUXC_FC_B11 20
`define MMUXC_IMP0_LK18 13
`define MMUXC_IMP0_LK19 12
`define MMUXC_EXT_EN 31
`define MMUXC_SEG_T 31
`define MMUXC_IDX_HI 16
`define MMUXC_IDX_LO 12
`define MMUXC_SEL_HI 31
`define MMUXC_SEL_LO 28
`define MMUXC_PPG_C 7
`define MMUXC_VEC_ALIGN 20'h00600
`define MMUXC_RST_WORD 32'h00000000
`endif

// ==== src/mmuxc_pkg.sv ====
// types shared by the mmu exception/tlb control block
// no surroundings assumed
package mmuxc_pkg;
  typedef enum logic [3:0] {
    ACC_FETCH = 4'h0, ACC_LOAD = 4'h1, ACC_STORE = 4'h2, ACC_ZERO = 4'h3,
    ACC_RSV_LD = 4'h4, ACC_RSV_ST = 4'h5, ACC_EXT_IN = 4'h6, ACC_EXT_OUT = 4'h7,
    ACC_FP_LD = 4'h8, ACC_FP_ST = 4'h9, ACC_MULT_LD = 4'hA, ACC_MULT_ST = 4'hB
  } mmuxc_acc_e;
  typedef enum logic [2:0] {
    EXC_NONE = 3'h0, EXC_INSTR_MISS_ADDR_REG = 3'h1, EXC_DLMISS = 3'h2, EXC_DSMISS = 3'h3,
    EXC_ALIGN = 3'h4, EXC_DSTOR = 3'h5
  } mmuxc_exc_e;
  typedef enum logic [3:0] {
    OP_MTSEG = 4'h0, OP_MTSEG_IND = 4'h1, OP_MFSEG = 4'h2, OP_MFSEG_IND = 4'h3,
    OP_INV_ENT = 4'h4, OP_INV_ALL = 4'h5, OP_INV_SYNC = 4'h6, OP_LOAD_I = 4'h7,
    OP_LOAD_D = 4'h8
  } mmuxc_op_e;
  typedef enum logic [0:0] {ST_RUN = 1'b0, ST_SYNC = 1'b1} mmuxc_state_e;
endpackage : mmuxc_pkg

// ==== src/mmuxc_tlb.sv ====
// two-way translation buffer: lookup, load into a victim way, invalidate a set
// one index serves lookup, load and invalidate; the caller muxes it
`timescale 1ns/1ns
`default_nettype none
module mmuxc_tlb #(
  parameter int SETS = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [$clog2(SETS)-1:0] idx,
  input wire logic [31:0] key,
  output logic hit,
  output logic [31:0] hit_ppg,
  input wire logic load_en,
  input wire logic [31:0] load_cmp,
  input wire logic [31:0] load_ppg,
  input wire logic inv_en
);
  logic [1:0] vld_r [SETS];
  logic [31:0] cmp_r [SETS][2];
  logic [31:0] ppg_r [SETS][2];
  logic [SETS-1:0] vict_r;

  // the index is five effective-address bits wide
  if (SETS != 32) begin : g_chk
    $error("mmuxc_tlb: SETS must be 32");
  end

  always_comb begin
    hit = 1'b0;
    hit_ppg = 32'h00000000;
    for (int w = 0; w < 2; w++) begin
      if (vld_r[idx][w] && cmp_r[idx][w] == key) begin
        hit = 1'b1;
        hit_ppg = ppg_r[idx][w];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < SETS; s++) begin
        vld_r[s] <= 2'h0;
      end
    end else if (inv_en) begin
      vld_r[idx] <= 2'h0;
    end else if (load_en) begin
      vld_r[idx][vict_r[idx]] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (load_en && !inv_en) begin
      cmp_r[idx][vict_r[idx]] <= load_cmp;
      ppg_r[idx][vict_r[idx]] <= load_ppg;
    end
  end

  // round-robin victim keeps the most recent load resident
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vict_r <= '0;
    end else if (load_en && !inv_en) begin
      vict_r[idx] <= ~vict_r[idx];
    end
  end
endmodule : mmuxc_tlb
`default_nettype wire

// ==== src/mmuxc_fault.sv ====
// combinational fault classifier for one access
// inputs are the state of the cycle in which the access is presented
`timescale 1ns/1ns
`default_nettype none
`include "mmuxc_regs.svh"
module mmuxc_fault (
  input wire mmuxc_pkg::mmuxc_acc_e kind,
  input wire logic xlate_i,
  input wire logic xlate_d,
  input wire logic misal,
  input wire logic wt,
  input wire logic ci,
  input wire logic dlock,
  input wire logic swap,
  input wire logic ext_en,
  input wire logic seg_t,
  input wire logic hit,
  input wire logic changed,
  output mmuxc_pkg::mmuxc_exc_e exc,
  output logic [31:0] fc
);
  logic is_ext;
  logic is_rsv;
  logic is_fp;
  logic is_mult;
  logic is_st;

  always_comb begin
    is_ext = kind == mmuxc_pkg::ACC_EXT_IN || kind == mmuxc_pkg::ACC_EXT_OUT;
    is_rsv = kind == mmuxc_pkg::ACC_RSV_LD || kind == mmuxc_pkg::ACC_RSV_ST;
    is_fp = kind == mmuxc_pkg::ACC_FP_LD || kind == mmuxc_pkg::ACC_FP_ST;
    is_mult = kind == mmuxc_pkg::ACC_MULT_LD || kind == mmuxc_pkg::ACC_MULT_ST;
    is_st = kind == mmuxc_pkg::ACC_STORE || kind == mmuxc_pkg::ACC_RSV_ST ||
            kind == mmuxc_pkg::ACC_EXT_OUT || kind == mmuxc_pkg::ACC_FP_ST ||
            kind == mmuxc_pkg::ACC_MULT_ST || kind == mmuxc_pkg::ACC_ZERO;
    exc = mmuxc_pkg::EXC_NONE;
    fc = 32'h00000000;
    // a page fault is never raised here, only buffer misses, alignment and data-storage faults
    if (kind == mmuxc_pkg::ACC_FETCH) begin
      if (xlate_i && !hit) begin
        exc = mmuxc_pkg::EXC_INSTR_MISS_ADDR_REG;
      end
    end else if (misal) begin
      exc = mmuxc_pkg::EXC_ALIGN;
    end else if (kind == mmuxc_pkg::ACC_ZERO && (wt || ci || dlock)) begin
      exc = mmuxc_pkg::EXC_ALIGN;
    end else if (is_mult && swap) begin
      exc = mmuxc_pkg::EXC_ALIGN;
    end else if (!xlate_d) begin
      exc = mmuxc_pkg::EXC_NONE;
    end else if (is_ext && !ext_en) begin
      exc = mmuxc_pkg::EXC_DSTOR;
      fc[`MMUXC_FC_B11] = 1'b1;
    end else if (seg_t && (is_ext || is_rsv || is_fp || kind == mmuxc_pkg::ACC_LOAD ||
                           kind == mmuxc_pkg::ACC_STORE)) begin
      exc = mmuxc_pkg::EXC_DSTOR;
      fc[`MMUXC_FC_B5] = 1'b1;
    end else if (is_st && (!hit || !changed)) begin
      exc = mmuxc_pkg::EXC_DSMISS;
    end else if (!is_st && !hit) begin
      exc = mmuxc_pkg::EXC_DLMISS;
    end
  end
endmodule : mmuxc_fault
`default_nettype wire

// ==== dv/mmuxc_sync_model.sv ====
// far-side sync source: holds the tlb sync input high for a chosen span
// assumes go is a one-cycle pulse from the bench, synchronous to clk
`timescale 1ns/1ns
`default_nettype none
module mmuxc_sync_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic go,
  input wire logic [7:0] span,
  output logic tlbi_sync
);
  logic [7:0] cnt_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 8'h00;
    end else if (go) begin
      cnt_r <= span;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  // span zero answers at once, a long span models a slow partner
  assign tlbi_sync = (cnt_r != 8'h00);
endmodule : mmuxc_sync_model
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for mmuxc_top: register, access and op tasks against a reference model
// assumes the sync source model drives tlbi_sync
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk, arst_n, reg_wr, reg_rd, acc_valid, acc_misal, acc_wt, acc_ci, op_valid, go, stl;
  logic exc_valid, acc_hit, op_done, op_illegal, tlbi_sync, core_stall;
  logic [7:0] reg_addr, span;
  logic [31:0] reg_wdata, reg_rdata, acc_ea, acc_ppg, op_rs, op_rb, op_rdata, seed, r, ea9;
  logic [19:0] exc_vector;
  logic [3:0] op_seg;
  mmuxc_pkg::mmuxc_acc_e acc_kind;
  mmuxc_pkg::mmuxc_exc_e exc_code;
  mmuxc_pkg::mmuxc_op_e op_code;
  int n_tests, bad_count, i, j;
  logic [31:0] ms, imp, ext, ppg, seg[16], key[2][32], pg[2][32], cmpw[2], ea_r[4];
  bit v[2][32];
  mmuxc_top dut (.*);
  mmuxc_sync_model sm (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [31:0] cw(input logic [31:0] ea);
    return {1'b1, seg[ea[31:28]][23:0], 1'b0, ea[27:22]};
  endfunction : cw
  function automatic mmuxc_pkg::mmuxc_exc_e f_exp(input mmuxc_pkg::mmuxc_acc_e k, input logic [31:0] ea,
      input logic mis, input logic [1:0] wi, input logic h, input int s);
    if (k == mmuxc_pkg::ACC_FETCH) return (ms[5] && !h) ? mmuxc_pkg::EXC_INSTR_MISS_ADDR_REG : mmuxc_pkg::EXC_NONE;
    if (mis || (k == mmuxc_pkg::ACC_ZERO && (wi != 2'b00 || imp[13:12] != 2'b00))) return mmuxc_pkg::EXC_ALIGN;
    if ((k == mmuxc_pkg::ACC_MULT_LD || k == mmuxc_pkg::ACC_MULT_ST) && ms[0]) return mmuxc_pkg::EXC_ALIGN;
    if (!ms[4]) return mmuxc_pkg::EXC_NONE;
    if ((k == mmuxc_pkg::ACC_EXT_IN || k == mmuxc_pkg::ACC_EXT_OUT) && !ext[31]) return mmuxc_pkg::EXC_DSTOR;
    if (seg[ea[31:28]][31] && !(k inside {mmuxc_pkg::ACC_MULT_LD, mmuxc_pkg::ACC_MULT_ST, mmuxc_pkg::ACC_ZERO}))
      return mmuxc_pkg::EXC_DSTOR;
    if (k inside {mmuxc_pkg::ACC_STORE, mmuxc_pkg::ACC_RSV_ST, mmuxc_pkg::ACC_EXT_OUT, mmuxc_pkg::ACC_FP_ST,
                  mmuxc_pkg::ACC_MULT_ST, mmuxc_pkg::ACC_ZERO})
      return (h && pg[1][s][7]) ? mmuxc_pkg::EXC_NONE : mmuxc_pkg::EXC_DSMISS;
    return h ? mmuxc_pkg::EXC_NONE : mmuxc_pkg::EXC_DLMISS;
  endfunction : f_exp
  task automatic ck(input bit ok, input string m);
    n_tests++;
    if (!ok) begin
      $display("FAIL %0t %s", $time, m);
      bad_count++;
    end
  endtask : ck
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    case (a)
      8'h00: ms = d;
      8'h04: imp = d;
      8'h08: ext = d;
      8'h24: ppg = d;
      default: ;
    endcase
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    ck((reg_rdata & m) === (e & m), "register read mismatch");
  endtask : rc
  task automatic ac(input mmuxc_pkg::mmuxc_acc_e k, input logic [31:0] ea, input logic mis, input logic [1:0] wi);
    int b, s;
    logic h;
    mmuxc_pkg::mmuxc_exc_e e;
    b = (k != mmuxc_pkg::ACC_FETCH);
    s = ea[16:12];
    h = v[b][s] && (key[b][s] === cw(ea));
    e = f_exp(k, ea, mis, wi, h, s);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_kind <= k;
    acc_ea <= ea;
    acc_misal <= mis;
    acc_wt <= wi[1];
    acc_ci <= wi[0];
    @(posedge clk);
    acc_valid <= 1'b0;
    #1;
    if (stl) begin
      ck(exc_valid === 1'b0, "access answered while stalled");
    end else begin
      ck(exc_valid === (e != mmuxc_pkg::EXC_NONE) && exc_code === e, "exception code");
      ck(exc_vector === ((e == mmuxc_pkg::EXC_ALIGN) ? 20'h00600 : 20'h00000), "vector");
      if (e == mmuxc_pkg::EXC_NONE && h) ck(acc_hit === 1'b1 && acc_ppg === pg[b][s], "hit word");
      if (e == mmuxc_pkg::EXC_INSTR_MISS_ADDR_REG || e == mmuxc_pkg::EXC_DLMISS || e == mmuxc_pkg::EXC_DSMISS) begin
        cmpw[b] = cw(ea);
        // an instruction miss leaves the load/store bit alone
        rc(8'h0C, (e == mmuxc_pkg::EXC_INSTR_MISS_ADDR_REG) ? 32'h00040000 : 32'h00050000,
           {13'h0000, e == mmuxc_pkg::EXC_INSTR_MISS_ADDR_REG, 1'b0, e == mmuxc_pkg::EXC_DLMISS, 16'h0000});
        rc(8'h00, 32'h00020000, 32'h00020000);
        rc(b ? 8'h18 : 8'h14, 32'hFFFFFFFF, ea);
        rc(b ? 8'h20 : 8'h1C, 32'hFFFFFFFF, cmpw[b]);
      end
      if (e == mmuxc_pkg::EXC_DSTOR) rc(8'h10, ext[31] ? 32'h04000000 : 32'h00100000, 32'hFFFFFFFF);
    end
  endtask : ac
  task automatic op(input mmuxc_pkg::mmuxc_op_e c, input logic [3:0] sg, input logic [31:0] rs, input logic [31:0] rb);
    int b, s;
    b = (c == mmuxc_pkg::OP_LOAD_D);
    s = rb[16:12];
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_seg <= sg;
    op_rs <= rs;
    op_rb <= rb;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    ck(op_done === 1'b1 && op_illegal === (c == mmuxc_pkg::OP_INV_ALL || c > 4'h8), "op answer");
    case (c)
      mmuxc_pkg::OP_MTSEG: seg[sg] = rs;
      mmuxc_pkg::OP_MTSEG_IND: seg[rb[31:28]] = rs;
      mmuxc_pkg::OP_MFSEG: ck(op_rdata === seg[sg], "segment read");
      mmuxc_pkg::OP_MFSEG_IND: ck(op_rdata === seg[rb[31:28]], "segment read");
      mmuxc_pkg::OP_INV_ENT: begin
        v[0][s] = 1'b0;
        v[1][s] = 1'b0;
      end
      mmuxc_pkg::OP_LOAD_I, mmuxc_pkg::OP_LOAD_D: begin
        key[b][s] = cmpw[b];
        pg[b][s] = ppg;
        v[b][s] = 1'b1;
      end
      default: ;
    endcase
  endtask : op
  task automatic wrap_up;
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial begin
    #(8 * 30000);
    bad_count++;
    wrap_up;
  end
  initial begin
    {reg_wr, reg_rd, acc_valid, acc_misal, acc_wt, acc_ci, op_valid, go, stl, arst_n} = '0;
    {reg_addr, reg_wdata, acc_ea, op_seg, op_rs, op_rb, ms, imp, ext, ppg} = '0;
    acc_kind = mmuxc_pkg::ACC_FETCH;
    op_code = mmuxc_pkg::OP_MTSEG;
    span = 8'h08;
    seed = 32'h00000E94;
    for (i = 0; i < 16; i++) seg[i] = '0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rc(8'h0C, 32'hFFFFFFFF, 32'h00000000);
    rc(8'h80, 32'hFFFFFFFF, 32'h00000000);
    wr(8'h14, xs());
    rc(8'h14, 32'hFFFFFFFF, 32'h00000000);
    // software synthesizes a page-fault cause itself
    wr(8'h10, 32'h40000000);
    rc(8'h10, 32'hFFFFFFFF, 32'h40000000);
    ac(mmuxc_pkg::ACC_EXT_IN, xs(), 1'b0, 2'b00);
    ac(mmuxc_pkg::ACC_LOAD, xs(), 1'b1, 2'b00);
    for (i = 0; i < 16; i++) begin
      r = xs();
      r[31] = (i == 9);
      if (i[0]) op(mmuxc_pkg::OP_MTSEG_IND, 4'h0, r, {i[3:0], 28'h0000000});
      else op(mmuxc_pkg::OP_MTSEG, i[3:0], r, 32'h00000000);
    end
    for (i = 0; i < 16; i++) begin
      op(mmuxc_pkg::OP_MFSEG, i[3:0], 32'h00000000, 32'h00000000);
      op(mmuxc_pkg::OP_MFSEG_IND, ~i[3:0], 32'h00000000, {i[3:0], 28'h0000000});
    end
    op(mmuxc_pkg::OP_INV_ALL, 4'h0, 32'h00000000, 32'h00000000);
    op(mmuxc_pkg::mmuxc_op_e'(4'hF), 4'h0, 32'h00000000, 32'h00000000);
    wr(8'h00, 32'h00000030);
    wr(8'h08, 32'h80000000);
    for (j = 0; j < 4; j++) begin
      r = xs();
      ea_r[j] = {1'b0, r[30:17], j[4:0], r[11:0]};
      ac(mmuxc_pkg::ACC_LOAD, ea_r[j], 1'b0, 2'b00);
      ac(mmuxc_pkg::ACC_STORE, ea_r[j], 1'b0, 2'b00);
      ac(mmuxc_pkg::ACC_FETCH, ea_r[j], 1'b0, 2'b00);
      r = xs();
      r[7] = j[0];
      wr(8'h24, r);
      op(mmuxc_pkg::OP_LOAD_D, 4'h0, 32'h00000000, ea_r[j]);
      op(mmuxc_pkg::OP_LOAD_I, 4'h0, 32'h00000000, ea_r[j]);
      ac(mmuxc_pkg::ACC_LOAD, ea_r[j], 1'b0, 2'b00);
      ac(mmuxc_pkg::ACC_STORE, ea_r[j], 1'b0, 2'b00);
      ac(mmuxc_pkg::ACC_FETCH, ea_r[j], 1'b0, 2'b00);
    end
    // pages settled and tables changed: purge set 1 through an address of another page
    r = xs();
    op(mmuxc_pkg::OP_INV_ENT, 4'h0, 32'h00000000, {r[31:17], 5'h01, r[11:0]});
    ac(mmuxc_pkg::ACC_LOAD, ea_r[1], 1'b0, 2'b00);
    ac(mmuxc_pkg::ACC_FETCH, ea_r[1], 1'b0, 2'b00);
    ac(mmuxc_pkg::ACC_LOAD, ea_r[0], 1'b0, 2'b00);
    ac(mmuxc_pkg::ACC_ZERO, ea_r[0], 1'b0, 2'b10);
    ac(mmuxc_pkg::ACC_ZERO, ea_r[0], 1'b0, 2'b01);
    wr(8'h04, 32'h00002000);
    ac(mmuxc_pkg::ACC_ZERO, ea_r[0], 1'b0, 2'b00);
    wr(8'h04, 32'h00001000);
    ac(mmuxc_pkg::ACC_ZERO, ea_r[0], 1'b0, 2'b00);
    ac(mmuxc_pkg::ACC_STORE, ea_r[2], 1'b1, 2'b00);
    r = xs();
    ea9 = {4'h9, r[27:0]};
    for (i = 1; i < 10; i++) if (i != 3) ac(mmuxc_pkg::mmuxc_acc_e'(i[3:0]), ea9, 1'b0, 2'b00);
    wr(8'h08, 32'h00000000);
    ac(mmuxc_pkg::ACC_EXT_IN, ea_r[0], 1'b0, 2'b00);
    ac(mmuxc_pkg::ACC_EXT_OUT, ea9, 1'b0, 2'b00);
    wr(8'h00, 32'h00000031);
    ac(mmuxc_pkg::ACC_MULT_LD, ea_r[0], 1'b0, 2'b00);
    ac(mmuxc_pkg::ACC_MULT_ST, ea_r[0], 1'b0, 2'b00);
    op(mmuxc_pkg::OP_INV_SYNC, 4'h0, 32'h00000000, 32'h00000000);
    ck(core_stall === 1'b0, "stall with sync low");
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    op(mmuxc_pkg::OP_INV_SYNC, 4'h0, 32'h00000000, 32'h00000000);
    ck(core_stall === 1'b1, "no stall with sync high");
    stl = 1'b1;
    ac(mmuxc_pkg::ACC_LOAD, ea_r[0], 1'b0, 2'b00);
    for (i = 0; i < 20 && tlbi_sync; i++) begin
      @(posedge clk);
      #1;
    end
    ck(core_stall === 1'b1, "stall ended early");
    @(posedge clk);
    #1;
    ck(core_stall === 1'b0, "stall held too long");
    stl = 1'b0;
    ac(mmuxc_pkg::ACC_LOAD, ea_r[0], 1'b0, 2'b00);
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
